/* File: rtl/phy_mgmt_pkg.sv */
// constants for the phy management register bank
package phy_mgmt_pkg;
	// register addresses
	localparam logic [4:0]  ADDR_VENDOR    = 5'h10;
	localparam logic [4:0]  ADDR_IRQ       = 5'h11;
	localparam logic [4:0]  ADDR_DIAG      = 5'h12;
	localparam logic [4:0]  ADDR_GAIN      = 5'h13;
	localparam logic [4:0]  ADDR_LED       = 5'h17;
	localparam logic [4:0]  ADDR_XOVER     = 5'h18;
	// reset values and writable masks
	localparam logic [15:0] VENDOR_RESET   = 16'h0140;
	localparam logic [15:0] VENDOR_WMASK   = 16'hDC33;
	localparam logic [15:0] IRQ_RESET      = 16'h0000;
	localparam logic [15:0] GAIN_RESET     = 16'h4000;
	localparam logic [15:0] GAIN_WMASK     = 16'hC000;
	localparam logic [15:0] LED_RESET      = 16'h0010;
	localparam logic [15:0] LED_WMASK      = 16'h00FF;
	localparam logic [15:0] XOVER_RESET    = 16'h00C0;
	localparam logic [15:0] ZERO16         = 16'h0000;
	// vendor control bit positions
	localparam int          B_IRQ_POL      = 14;
	localparam int          B_TX_FLOAT     = 12;
	localparam int          B_COLL_INHIBIT = 11;
	localparam int          B_NAT_LOOP     = 10;
	localparam int          B_AUTO_POLARITY_DISABLE_DIS     = 5;
	localparam int          B_RX_INVERT    = 4;
	localparam int          B_CODING_BYP   = 1;
	localparam int          B_RX_CLK_GATE  = 0;
	// event flag positions, bit 7 down to bit 0
	localparam int          E_JABBER       = 7;
	localparam int          E_RX_ERROR     = 6;
	localparam int          E_PAGE_RX      = 5;
	localparam int          E_PAR_FAULT    = 4;
	localparam int          E_PARTNER_ACK  = 3;
	localparam int          E_LINK_CHANGE  = 2;
	localparam int          E_REMOTE_FAULT = 1;
	localparam int          E_NEG_DONE     = 0;
	// diagnostic bit positions
	localparam int          D_NEG_FAIL     = 12;
	localparam int          D_FULL_DUPLEX  = 11;
	localparam int          D_RATE_100     = 10;
	localparam int          D_SIG_DETECT   = 9;
	localparam int          D_PLL_LOCK     = 8;
	// field positions
	localparam int          LED_FIRST_LO   = 4;
	localparam int          GAIN_LO        = 14;
	// indicator source codes
	localparam logic [3:0]  LED_LINK       = 4'h0;
	localparam logic [3:0]  LED_ACTIVITY   = 4'h1;
	localparam logic [3:0]  LED_SPEED_100  = 4'h5;
	localparam logic [3:0]  LED_SPEED_10   = 4'h6;
	localparam logic [3:0]  LED_DUPLEX     = 4'h7;
	localparam logic [3:0]  LED_LINK_BLINK = 4'h8;
endpackage : phy_mgmt_pkg

/* File: rtl/event_flag_if.sv */
// carrier between the register bank and its event flag store
`timescale 1ns/1ps
interface event_flag_if;
	logic [7:0] evt;
	logic       clr;
	logic [7:0] flags;
	modport store (input evt, input clr, output flags);
	modport ctrl  (output evt, output clr, input flags);
endinterface : event_flag_if

/* File: rtl/event_flag_store.sv */
// sticky event flags, cleared by a status read
`timescale 1ns/1ps
module event_flag_store
	import phy_mgmt_pkg::*;
(
	// clock and reset
	input  wire logic   core_clk,
	input  wire logic   rst_b,
	// flag carrier
	event_flag_if.store fl
);
	typedef struct packed {
		logic [7:0] flags;
	} state_s;

	state_s st;
	state_s next_st;

	assign fl.flags = st.flags;

	always_comb begin
		next_st = st;
		for (int i = 0; i < 8; i++) begin
			// a new event beats the clear
			next_st.flags[i] = (st.flags[i] & ~fl.clr) | fl.evt[i];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
		(fl.evt != 8'h00) |=> ((fl.flags & $past(fl.evt)) == $past(fl.evt)))
		else $error("event flag lost");
endmodule : event_flag_store

/* File: rtl/phy_mgmt_regs.sv */
// phy vendor, event, diagnostic, gain, indicator and crossover registers
`timescale 1ns/1ps
module phy_mgmt_regs
	import phy_mgmt_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// management access
	input  wire logic [4:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// phy core status
	input  wire logic        speed_100,
	input  wire logic        basic_loopback,
	input  wire logic        link_ok,
	input  wire logic        rx_activity,
	input  wire logic        tx_activity,
	input  wire logic        polarity_reversed,
	input  wire logic        frame_tx_done,
	input  wire logic        blink_tick,
	// phy events
	input  wire logic        jabber_evt,
	input  wire logic        rx_error_evt,
	input  wire logic        page_rx_evt,
	input  wire logic        parallel_fault_evt,
	input  wire logic        partner_ack_evt,
	input  wire logic        remote_fault_evt,
	input  wire logic        neg_done_evt,
	input  wire logic        neg_fail_evt,
	// negotiation results
	input  wire logic        neg_full_duplex,
	input  wire logic        neg_rate_100,
	input  wire logic        receive_signal_detected,
	input  wire logic        rx_pll_locked,
	// line data
	input  wire logic        tx_pos_data,
	input  wire logic        tx_neg_data,
	input  wire logic        tx_serial_data,
	input  wire logic        rx_line_data,
	output logic             tx_line_pos,
	output logic             tx_line_pos_oe,
	output logic             tx_line_neg,
	output logic             tx_line_neg_oe,
	output logic             rx_data,
	// controls to the phy core
	output logic             collision_test,
	output logic             coding_bypass,
	output logic             rx_clk_stop,
	output logic      [1:0]  tx_gain,
	// indicators and interrupt
	output logic             first_indicator,
	output logic             second_indicator,
	output logic             phy_irq_line
);
	typedef struct packed {
		logic [15:0] vendor;
		logic [7:0]  irq_en;
		logic        neg_fail;
		logic [15:0] gain;
		logic [15:0] led;
		logic [15:0] xover;
		logic [15:0] rdata;
		logic        link_prev;
		logic        blink;
		logic        tx_pos;
		logic        tx_neg;
		logic        tx_oe;
		logic        rx_out;
		logic        coll;
		logic        bypass;
		logic        clk_stop;
		logic        ind_first;
		logic        ind_second;
		logic        irq;
	} state_s;

	state_s st;
	state_s next_st;

	event_flag_if fl ();

	event_flag_store u_flags (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.fl       (fl.store)
	);

	logic       auto_invert;
	logic       invert;
	logic       irq_level;
	logic       activity;
	logic [15:0] vendor_view;
	logic [15:0] diag_view;

	function automatic logic led_pick(input logic [3:0] code, input logic lnk,
		input logic act, input logic spd, input logic dup, input logic blk);
		logic v;
		v = 1'b0;
		case (code)
			LED_LINK:       v = lnk;
			LED_ACTIVITY:   v = act;
			LED_SPEED_100:  v = spd;
			LED_SPEED_10:   v = ~spd;
			LED_DUPLEX:     v = dup;
			LED_LINK_BLINK: v = lnk & ~(act & blk);
			default:        v = 1'b0;
		endcase
		return v;
	endfunction : led_pick

	always_comb begin
		auto_invert = ~st.vendor[B_AUTO_POLARITY_DISABLE_DIS] & ~speed_100 & polarity_reversed;
		invert = st.vendor[B_AUTO_POLARITY_DISABLE_DIS] ? st.vendor[B_RX_INVERT] : auto_invert;
		vendor_view = st.vendor;
		if (!st.vendor[B_AUTO_POLARITY_DISABLE_DIS]) begin
			vendor_view[B_RX_INVERT] = auto_invert;
		end
		diag_view = ZERO16;
		diag_view[D_NEG_FAIL] = st.neg_fail;
		diag_view[D_FULL_DUPLEX] = neg_full_duplex;
		diag_view[D_RATE_100] = neg_rate_100;
		diag_view[D_SIG_DETECT] = receive_signal_detected;
		diag_view[D_PLL_LOCK] = rx_pll_locked;
		irq_level = |(fl.flags & st.irq_en);
		activity = rx_activity | tx_activity;
		// flag map, bit 7 down to bit 0
		fl.evt = '0;
		fl.evt[E_JABBER] = jabber_evt;
		fl.evt[E_RX_ERROR] = rx_error_evt;
		fl.evt[E_PAGE_RX] = page_rx_evt;
		fl.evt[E_PAR_FAULT] = parallel_fault_evt;
		fl.evt[E_PARTNER_ACK] = partner_ack_evt;
		fl.evt[E_LINK_CHANGE] = st.link_prev & ~link_ok;
		fl.evt[E_REMOTE_FAULT] = remote_fault_evt;
		fl.evt[E_NEG_DONE] = neg_done_evt;
		fl.clr = reg_rd && (reg_addr == ADDR_IRQ);

		next_st = st;
		next_st.link_prev = link_ok;
		if (blink_tick) begin
			next_st.blink = ~st.blink;
		end
		// failure flag: set beats the read clear
		next_st.neg_fail = (st.neg_fail & ~(reg_rd && reg_addr == ADDR_DIAG))
			| neg_fail_evt;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_VENDOR: next_st.rdata = vendor_view;
				ADDR_IRQ:    next_st.rdata = {st.irq_en, fl.flags};
				ADDR_DIAG:   next_st.rdata = diag_view;
				ADDR_GAIN:   next_st.rdata = st.gain;
				ADDR_LED:    next_st.rdata = st.led;
				ADDR_XOVER:  next_st.rdata = st.xover;
				default:     next_st.rdata = ZERO16;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				ADDR_VENDOR: begin
					next_st.vendor = (reg_wdata & VENDOR_WMASK)
						| (VENDOR_RESET & ~VENDOR_WMASK);
					if (!st.vendor[B_AUTO_POLARITY_DISABLE_DIS]) begin
						next_st.vendor[B_RX_INVERT] = st.vendor[B_RX_INVERT];
					end
				end
				ADDR_IRQ:    next_st.irq_en = reg_wdata[15:8];
				ADDR_GAIN:   next_st.gain = reg_wdata & GAIN_WMASK;
				ADDR_LED:    next_st.led = reg_wdata & LED_WMASK;
				ADDR_XOVER:  next_st.xover = reg_wdata;
				default:     next_st.xover = st.xover;
			endcase
		end
		next_st.tx_pos = tx_pos_data;
		next_st.tx_neg = tx_neg_data;
		next_st.tx_oe = ~st.vendor[B_TX_FLOAT];
		if (st.vendor[B_NAT_LOOP] && !speed_100) begin
			next_st.rx_out = tx_serial_data;
		end else begin
			next_st.rx_out = rx_line_data ^ invert;
		end
		next_st.coll = frame_tx_done & ~speed_100 & ~st.vendor[B_COLL_INHIBIT];
		next_st.bypass = st.vendor[B_CODING_BYP] & speed_100;
		next_st.clk_stop = st.vendor[B_RX_CLK_GATE] & speed_100 & ~basic_loopback
			& ~rx_activity;
		next_st.ind_first = led_pick(st.led[LED_FIRST_LO +: 4], link_ok, activity,
			speed_100, neg_full_duplex, st.blink);
		next_st.ind_second = led_pick(st.led[3:0], link_ok, activity,
			speed_100, neg_full_duplex, st.blink);
		// polarity bit selects the level driven to the mac
		next_st.irq = st.vendor[B_IRQ_POL] ? irq_level : ~irq_level;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.vendor <= VENDOR_RESET;
			st.irq_en <= IRQ_RESET[15:8];
			st.gain <= GAIN_RESET;
			st.led <= LED_RESET;
			st.xover <= XOVER_RESET;
			st.irq <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign tx_line_pos = st.tx_pos;
	assign tx_line_neg = st.tx_neg;
	assign tx_line_pos_oe = st.tx_oe;
	assign tx_line_neg_oe = st.tx_oe;
	assign rx_data = st.rx_out;
	assign collision_test = st.coll;
	assign coding_bypass = st.bypass;
	assign rx_clk_stop = st.clk_stop;
	assign tx_gain = st.gain[GAIN_LO +: 2];
	assign first_indicator = st.ind_first;
	assign second_indicator = st.ind_second;
	assign phy_irq_line = st.irq;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	a_float_both_lines: assert property (
		st.vendor[B_TX_FLOAT] |=> (!tx_line_pos_oe && !tx_line_neg_oe))
		else $error("transmit lines driven while float set");
	a_collision_pulse_gate: assert property (
		(frame_tx_done && !speed_100 && !st.vendor[B_COLL_INHIBIT]) |=> collision_test)
		else $error("collision test pulse missing");
	a_collision_inhibited: assert property (
		collision_test |-> ($past(st.vendor[B_COLL_INHIBIT]) == 1'b0 && !$past(speed_100)))
		else $error("collision test pulse not allowed");
	a_loopback_data_path: assert property (
		(st.vendor[B_NAT_LOOP] && !speed_100) |=> (rx_data == $past(tx_serial_data)))
		else $error("natural loopback data wrong");
	a_invert_forced: assert property (
		(st.vendor[B_AUTO_POLARITY_DISABLE_DIS] && !st.vendor[B_NAT_LOOP])
		|=> (rx_data == ($past(rx_line_data) ^ $past(st.vendor[B_RX_INVERT]))))
		else $error("forced receive inversion wrong");
	a_gating_loopback_off: assert property (
		basic_loopback |=> !rx_clk_stop)
		else $error("clock gating active in loopback");
	a_read_clears_flags: assert property (
		(reg_rd && reg_addr == ADDR_IRQ && fl.evt == 8'h00) |=> (fl.flags == 8'h00))
		else $error("status read did not clear flags");
	a_irq_enable_path: assert property (
		(st.vendor[B_IRQ_POL] == 1'b0 && (fl.flags & st.irq_en) != 8'h00)
		|=> !phy_irq_line)
		else $error("enabled flag did not assert interrupt");
	a_link_fall_only: assert property (
		($fell(link_ok)) |=> fl.flags[E_LINK_CHANGE])
		else $error("link fall not flagged");
	a_fail_sticky: assert property (
		(st.neg_fail && !(reg_rd && reg_addr == ADDR_DIAG)) |=> st.neg_fail)
		else $error("negotiation failure flag dropped");
	a_rsvd_vendor_fixed: assert property (
		((st.vendor & ~VENDOR_WMASK) == (VENDOR_RESET & ~VENDOR_WMASK)))
		else $error("reserved vendor bits changed");
	a_link_rise_quiet: assert property (
		(!fl.flags[E_LINK_CHANGE] && !(st.link_prev && !link_ok))
		|=> !fl.flags[E_LINK_CHANGE])
		else $error("link change flagged without link fall");
	a_rx_clock_gated: assert property (
		(st.vendor[B_RX_CLK_GATE] && speed_100 && !basic_loopback && !rx_activity)
		|=> rx_clk_stop)
		else $error("receive clock not gated while idle");
	a_bypass_at_speed: assert property (
		coding_bypass |-> $past(speed_100))
		else $error("coding bypass outside 100 Mb/s");
	a_fail_flag_set: assert property (
		neg_fail_evt |=> st.neg_fail)
		else $error("negotiation failure not recorded");

	c_status_read: cover property (reg_rd && reg_addr == ADDR_IRQ && fl.flags != 8'h00);
	c_irq_asserted: cover property ($fell(phy_irq_line));
	c_natural_loop: cover property (st.vendor[B_NAT_LOOP] && !speed_100);
	c_clock_gated: cover property (rx_clk_stop);
endmodule : phy_mgmt_regs

/* File: verif/mgmt_host_model.sv */
// management host model driving the register port of the phy bank
`timescale 1ns/1ps
module mgmt_host_model
	import phy_mgmt_pkg::*;
(
	// clock
	input  wire logic        core_clk,
	// register port
	output logic      [4:0]  reg_addr,
	output logic             reg_wr,
	output logic      [15:0] reg_wdata,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata
);
	initial begin
		reg_addr = 5'h00;
		reg_wr = 1'b0;
		reg_wdata = ZERO16;
		reg_rd = 1'b0;
	end
	// one-cycle write strobe, launched on the falling edge
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = (a == ADDR_VENDOR) ? (d & ~(16'h0001 << B_IRQ_POL)) : d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask : wr
	// polled read, answer registered at the taking edge and stands until the next read
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
endmodule : mgmt_host_model

/* File: verif/testbench.sv */
// self-checking bench for the phy management register bank
`timescale 1ns/1ps
module testbench
	import phy_mgmt_pkg::*;
;
	logic core_clk, rst_b, speed_100, basic_loopback, link_ok, rx_activity, polarity_reversed;
	logic frame_tx_done, neg_fail_evt, neg_full_duplex, neg_rate_100, rx_sig, rx_pll_locked;
	logic tx_serial_data, rx_line_data, reg_wr, reg_rd, tx_activity, blink_tick;
	logic [7:0] ev;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic tx_line_pos, tx_line_pos_oe, tx_line_neg, tx_line_neg_oe, rx_data, collision_test;
	logic coding_bypass, rx_clk_stop, first_indicator, second_indicator, phy_irq_line;
	logic [1:0] tx_gain;
	int err_total = 0;
	int comparisons = 0;
	mgmt_host_model host (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
	phy_mgmt_regs uut (.core_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
		.speed_100, .basic_loopback, .link_ok, .rx_activity, .tx_activity,
		.polarity_reversed, .frame_tx_done, .blink_tick, .jabber_evt(ev[7]),
		.rx_error_evt(ev[6]), .page_rx_evt(ev[5]), .parallel_fault_evt(ev[4]),
		.partner_ack_evt(ev[3]), .remote_fault_evt(ev[1]), .neg_done_evt(ev[0]),
		.neg_fail_evt, .neg_full_duplex, .neg_rate_100, .receive_signal_detected(rx_sig),
		.rx_pll_locked, .tx_pos_data(1'b1), .tx_neg_data(1'b0), .tx_serial_data,
		.rx_line_data, .tx_line_pos, .tx_line_pos_oe, .tx_line_neg, .tx_line_neg_oe, .rx_data,
		.collision_test, .coding_bypass, .rx_clk_stop, .tx_gain, .first_indicator,
		.second_indicator, .phy_irq_line);
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk16
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1
	task automatic settle();
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
	endtask : settle
	task automatic pulse_ev(input int k);
		@(negedge core_clk);
		ev[k] = 1'b1;
		@(negedge core_clk);
		ev[k] = 1'b0;
	endtask : pulse_ev
	task automatic frame_end(input logic exp);
		@(negedge core_clk);
		frame_tx_done = 1'b1;
		@(posedge core_clk);
		#1 chk1(collision_test, exp);
		@(negedge core_clk);
		frame_tx_done = 1'b0;
	endtask : frame_end
	task automatic end_of_test();
		$display("counts: comparisons=%0d mismatches=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic t_reset();
		logic [4:0] a [7] = '{ADDR_VENDOR, ADDR_IRQ, ADDR_DIAG, ADDR_GAIN, ADDR_LED,
			ADDR_XOVER, 5'h00};
		logic [15:0] e [7] = '{16'h0140, 16'h0000, 16'h0000, 16'h4000, 16'h0010,
			16'h00C0, 16'h0000};
		for (int i = 0; i < 7; i++) begin
			host.rd(a[i], v);
			chk16(v, e[i]);
		end
		chk1(phy_irq_line, 1'b1);
		chk1(tx_line_pos, 1'b1);
		chk1(tx_line_neg, 1'b0);
		chk16({14'h0000, tx_gain}, 16'h0001);
		$display("test reset values done");
	endtask : t_reset
	task automatic t_vendor();
		speed_100 = 1'b1;
		rx_line_data = 1'b1;
		// first write turns auto-polarity off, second lands the polarity bit
		host.wr(ADDR_VENDOR, 16'hFFFD);
		host.wr(ADDR_VENDOR, 16'hFFFD);
		host.rd(ADDR_VENDOR, v);
		chk16(v, 16'h9D71);
		settle();
		chk1(tx_line_pos_oe | tx_line_neg_oe, 1'b0);
		chk1(rx_data, 1'b0);
		chk1(coding_bypass, 1'b0);
		chk1(rx_clk_stop, 1'b1);
		basic_loopback = 1'b1;
		settle();
		chk1(rx_clk_stop, 1'b0);
		basic_loopback = 1'b0;
		// bypass on and clock gating off in this write; the bank lets both run together
		host.wr(ADDR_VENDOR, 16'hFFFE);
		settle();
		chk1(coding_bypass, 1'b1);
		chk1(rx_clk_stop, 1'b0);
		speed_100 = 1'b0;
		frame_end(1'b0);
		polarity_reversed = 1'b1;
		host.wr(ADDR_VENDOR, 16'h0000);
		host.rd(ADDR_VENDOR, v);
		chk16(v, 16'h0150);
		settle();
		chk1(rx_data, 1'b0);
		chk1(tx_line_pos_oe & tx_line_neg_oe, 1'b1);
		frame_end(1'b1);
		polarity_reversed = 1'b0;
		tx_serial_data = 1'b1;
		rx_line_data = 1'b0;
		host.wr(ADDR_VENDOR, 16'h0400);
		settle();
		chk1(rx_data, 1'b1);
		$display("test vendor controls done");
	endtask : t_vendor
	task automatic t_events();
		int k [7] = '{7, 6, 5, 4, 3, 1, 0};
		host.wr(ADDR_IRQ, 16'hFFFF);
		for (int i = 0; i < 7; i++) begin
			pulse_ev(k[i]);
			settle();
			chk1(phy_irq_line, 1'b0);
			host.rd(ADDR_IRQ, v);
			chk16(v, 16'hFF00 | (16'h0001 << k[i]));
			host.rd(ADDR_IRQ, v);
			chk16(v, 16'hFF00);
		end
		host.wr(ADDR_IRQ, 16'h0000);
		pulse_ev(7);
		settle();
		chk1(phy_irq_line, 1'b1);
		link_ok = 1'b1;
		host.rd(ADDR_IRQ, v);
		chk16(v, 16'h0080);
		link_ok = 1'b0;
		host.rd(ADDR_IRQ, v);
		chk16(v, 16'h0004);
		fork
			host.rd(ADDR_IRQ, v);
			pulse_ev(6);
		join
		chk16(v, 16'h0000);
		host.rd(ADDR_IRQ, v);
		chk16(v, 16'h0040);
		$display("test event flags done");
	endtask : t_events
	task automatic t_diag();
		{neg_full_duplex, neg_rate_100, rx_sig, rx_pll_locked} = 4'hF;
		@(negedge core_clk);
		neg_fail_evt = 1'b1;
		@(negedge core_clk);
		neg_fail_evt = 1'b0;
		host.rd(ADDR_DIAG, v);
		chk16(v, 16'h1F00);
		host.wr(ADDR_DIAG, 16'hFFFF);
		host.rd(ADDR_DIAG, v);
		chk16(v, 16'h0F00);
		{neg_full_duplex, neg_rate_100, rx_sig, rx_pll_locked} = 4'h0;
		host.wr(ADDR_GAIN, 16'hFFFF);
		host.rd(ADDR_GAIN, v);
		chk16(v, 16'hC000);
		chk16({14'h0000, tx_gain}, 16'h0003);
		$display("test diagnostics done");
	endtask : t_diag
	task automatic t_led();
		speed_100 = 1'b1;
		host.wr(ADDR_LED, 16'hFF50);
		host.rd(ADDR_LED, v);
		chk16(v, 16'h0050);
		settle();
		chk1(first_indicator, 1'b1);
		chk1(second_indicator, 1'b0);
		host.wr(ADDR_LED, 16'h0025);
		settle();
		chk1(first_indicator, 1'b0);
		chk1(second_indicator, 1'b1);
		link_ok = 1'b1;
		tx_activity = 1'b1;
		host.wr(ADDR_LED, 16'h0081);
		settle();
		chk1(first_indicator, 1'b1);
		chk1(second_indicator, 1'b1);
		@(negedge core_clk);
		blink_tick = 1'b1;
		@(negedge core_clk);
		blink_tick = 1'b0;
		settle();
		chk1(first_indicator, 1'b0);
		speed_100 = 1'b0;
		neg_full_duplex = 1'b1;
		host.wr(ADDR_LED, 16'h0076);
		settle();
		chk1(first_indicator, 1'b1);
		chk1(second_indicator, 1'b1);
		$display("test indicators done");
	endtask : t_led
	initial begin
		{rst_b, speed_100, basic_loopback, link_ok, rx_activity, polarity_reversed} = 6'h00;
		{frame_tx_done, neg_fail_evt, tx_serial_data, rx_line_data} = 4'h0;
		{tx_activity, blink_tick} = 2'h0;
		{neg_full_duplex, neg_rate_100, rx_sig, rx_pll_locked} = 4'h0;
		ev = 8'h00;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		rst_b = 1'b1;
		t_reset();
		t_vendor();
		t_events();
		t_diag();
		t_led();
		end_of_test();
	end
	initial begin
		#200000;
		err_total++;
		end_of_test();
	end
endmodule : testbench
